//--- src/sbsp_pkg.sv
// shared constants and types for the synchronous burst sram port
package sbsp_pkg;
    localparam int unsigned LANE_BITS     = 8;       // data bits per byte lane
    localparam int unsigned LANE_WORD     = 9;       // data byte plus parity bit
    localparam int unsigned PARITY_POS    = 8;       // parity bit position in a lane word
    localparam int unsigned DEF_LANES     = 4;       // 36-bit organisation
    localparam int unsigned DEF_ADDR_W    = 19;      // 512K words
    localparam int unsigned BEAT_W        = 2;       // burst counter width
    localparam int unsigned WAKE_CYCLES   = 2;       // wake-up time after sleep, in clock cycles
    localparam logic        ORDER_LINEAR  = 1'b0;    // burst order select level for linear bursts
    localparam logic [1:0]  BEAT_FIRST    = 2'h0;    // beat index of the first access
    localparam logic [1:0]  BEAT_STEP     = 2'h1;    // beat increment on advance
    localparam logic [1:0]  WAKE_FIRST    = 2'h0;    // wake counter start
    localparam logic [1:0]  WAKE_LAST     = 2'(WAKE_CYCLES - 1);

    // power state, one-hot
    typedef enum logic [2:0] {
        SLP_AWAKE  = 3'h1,
        SLP_ASLEEP = 3'h2,
        SLP_WAKING = 3'h4
    } sbsp_sleep_t;
endpackage

//--- src/sbsp_burst_order.sv
// burst order generator: low address bits from start value and beat index
`timescale 1ns/10ps
module sbsp_burst_order (
    input  wire logic [1:0] startBits,
    input  wire logic [1:0] beat,
    input  wire logic       burstOrderSelect,
    output logic      [1:0] burstBits
);
    // linear steps modulo four, interleaved flips bits by beat index
    always_comb begin
        if (burstOrderSelect == sbsp_pkg::ORDER_LINEAR) begin
            burstBits = startBits + beat;
        end else begin
            burstBits = startBits ^ beat;
        end
    end
endmodule

//--- src/sbsp_lane_decode.sv
// write decode: global write and per-lane byte writes into a lane mask
`timescale 1ns/10ps
module sbsp_lane_decode #(
    parameter int unsigned LANES = sbsp_pkg::DEF_LANES
) (
    input  wire logic             globalWrite_n,
    input  wire logic             byteWriteEn_n,
    input  wire logic [LANES-1:0] laneWrite_n,
    output logic      [LANES-1:0] laneMask,
    output logic                  writeReq
);
    genvar i;
    // each lane strobe gates only its own byte; global write takes all lanes
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            assign laneMask[i] = !globalWrite_n || (!byteWriteEn_n && !laneWrite_n[i]);
        end
    endgenerate

    // read when no lane is written
    assign writeReq = |laneMask;
endmodule

//--- src/sbsp_sync_burst_sram_port.sv
// synchronous burst sram port: decode, burst counter, array, sleep and output drive
//
// Contract
// - All inputs sampled on rising clock except output enable, order select, sleep.
// - Sleep request high enters power-down, keeps state, data pins high impedance.
// - After sleep request falls, operation resumes only after two wake-up cycles.
// - Read when global and byte write high, or byte write low, lanes high.
// - Global write low writes all lanes; lane writes need global high, byte low.
// - Each lane strobe gates its own byte and parity; 18-bit has two lanes.
// - Primary select sampled at address load; processor strobe ignored while it is high.
// - A controller strobe low, or processor strobe low with primary low, with any chip select inactive deselects, no access.
// - Processor strobe low with all selects active loads address, begins burst read.
// - Controller strobe low, selected: load address, write if composite write low.
// - Burst advance ignored on a processor strobe edge, honoured later.
// - Both strobes high, advance low: step counter, access next, composite write decides.
// - Both strobes high, advance high: repeat current address as wait state.
// - Counter starts at external low bits and wraps after the fourth access.
// - Order select low: linear sequence, start plus beat modulo four.
// - Order select high: interleaved sequence, start xor beat index.
// - Selected read with output enable low drives array data; high keeps high impedance.
// - Data pins high impedance in sleep, deselect and write, whatever output enable.
// - Pin behaviour of every access qualified by sleep request and output enable.
`timescale 1ns/10ps
module sbsp_sync_burst_sram_port #(
    parameter int unsigned LANES  = sbsp_pkg::DEF_LANES,
    parameter int unsigned ADDR_W = sbsp_pkg::DEF_ADDR_W
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic [ADDR_W-1:0]                      extAddr,
    input  wire logic                                   procAddrStrobe_n,
    input  wire logic                                   ctrlAddrStrobe_n,
    input  wire logic                                   burstStep_n,
    input  wire logic                                   globalWrite_n,
    input  wire logic                                   byteWriteEn_n,
    input  wire logic [LANES-1:0]                       laneWrite_n,
    input  wire logic                                   chipSelPrimary_n,
    input  wire logic                                   chipSelSecondary,
    input  wire logic                                   chipSelSecondary_n,
    input  wire logic                                   outputEnable_n,
    input  wire logic                                   burstOrderSelect,
    input  wire logic                                   sleepRequest,
    input  wire logic [LANES*sbsp_pkg::LANE_BITS-1:0]   dataLaneIn,
    input  wire logic [LANES-1:0]                       parityLaneIn,
    output logic      [LANES*sbsp_pkg::LANE_BITS-1:0]   dataLaneOut,
    output logic      [LANES-1:0]                       parityLaneOut,
    output logic                                        dataOe_n
);
    localparam int unsigned DEPTH = 2 ** ADDR_W;
    localparam int unsigned HI_W  = ADDR_W - sbsp_pkg::BEAT_W;

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous pins: two-flop synchronisers
    logic oeMeta;
    logic oeSync;
    logic orderMeta;
    logic orderSync;
    logic sleepMeta;
    logic sleepSync;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        oeMeta    <= outputEnable_n;
        oeSync    <= oeMeta;
        orderMeta <= burstOrderSelect;
        orderSync <= orderMeta;
        sleepMeta <= sleepRequest;
        sleepSync <= sleepMeta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // power state
    sbsp_pkg::sbsp_sleep_t sleepState;
    logic [1:0]            wakeCnt;
    logic                  awake;

    assign awake = (sleepState == sbsp_pkg::SLP_AWAKE);

    // sleep entry and two-cycle wake-up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleepState <= sbsp_pkg::SLP_AWAKE;
            wakeCnt    <= sbsp_pkg::WAKE_FIRST;
        end else begin
            case (sleepState)
                sbsp_pkg::SLP_AWAKE: begin
                    if (sleepSync) begin
                        sleepState <= sbsp_pkg::SLP_ASLEEP;
                    end
                end
                sbsp_pkg::SLP_ASLEEP: begin
                    wakeCnt <= sbsp_pkg::WAKE_FIRST;
                    if (!sleepSync) begin
                        sleepState <= sbsp_pkg::SLP_WAKING;
                    end
                end
                sbsp_pkg::SLP_WAKING: begin
                    if (sleepSync) begin
                        sleepState <= sbsp_pkg::SLP_ASLEEP;
                    end else if (wakeCnt == sbsp_pkg::WAKE_LAST) begin
                        sleepState <= sbsp_pkg::SLP_AWAKE;
                    end else begin
                        wakeCnt <= wakeCnt + sbsp_pkg::BEAT_STEP;
                    end
                end
                default: begin
                    sleepState <= sbsp_pkg::SLP_AWAKE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write decode
    logic [LANES-1:0] laneMask;
    logic             writeReq;

    sbsp_lane_decode #(
        .LANES (LANES)
    ) u_lane_decode (
        .globalWrite_n (globalWrite_n),
        .byteWriteEn_n (byteWriteEn_n),
        .laneWrite_n   (laneWrite_n),
        .laneMask      (laneMask),
        .writeReq      (writeReq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // cycle decode
    logic [HI_W-1:0] baseHigh;
    logic [1:0]      startBits;
    logic [1:0]      beat;
    logic            burstActive;
    logic            readCycle;
    logic            allSelected;
    logic            procTaken;
    logic            doLoad;
    logic            doDeselect;
    logic            doAccess;
    logic            accWrite;
    logic            doAdvance;
    logic [1:0]      next_beat;
    logic [1:0]      orderedBits;
    logic [ADDR_W-1:0] accAddr;

    assign allSelected = !chipSelPrimary_n && chipSelSecondary && !chipSelSecondary_n;
    // processor strobe counts only while the primary select is low
    assign procTaken   = !procAddrStrobe_n && !chipSelPrimary_n;

    // strobe priority, then burst continue or suspend
    always_comb begin
        doLoad     = 1'b0;
        doDeselect = 1'b0;
        doAccess   = 1'b0;
        accWrite   = 1'b0;
        doAdvance  = 1'b0;
        if (!awake) begin
            doLoad = 1'b0;
        end else if (procTaken) begin
            doLoad     = allSelected;
            doDeselect = !allSelected;
            doAccess   = allSelected;
        end else if (!ctrlAddrStrobe_n) begin
            doLoad     = allSelected;
            doDeselect = !allSelected;
            doAccess   = allSelected;
            accWrite   = allSelected && writeReq;
        end else if (burstActive) begin
            doAccess  = 1'b1;
            accWrite  = writeReq;
            doAdvance = !burstStep_n;
        end
    end

    assign next_beat = doLoad ? sbsp_pkg::BEAT_FIRST :
                       doAdvance ? beat + sbsp_pkg::BEAT_STEP : beat;

    sbsp_burst_order u_burst_order (
        .startBits        (doLoad ? extAddr[1:0] : startBits),
        .beat             (next_beat),
        .burstOrderSelect (orderSync),
        .burstBits        (orderedBits)
    );

    // a load uses the external address itself, a continue the counter
    assign accAddr = doLoad ? extAddr : {baseHigh, orderedBits};

    // address and burst registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            baseHigh    <= '0;
            startBits   <= sbsp_pkg::BEAT_FIRST;
            beat        <= sbsp_pkg::BEAT_FIRST;
            burstActive <= 1'b0;
        end else begin
            if (doLoad) begin
                baseHigh  <= extAddr[ADDR_W-1:sbsp_pkg::BEAT_W];
                startBits <= extAddr[1:0];
            end
            beat <= next_beat;
            if (doLoad) begin
                burstActive <= 1'b1;
            end else if (doDeselect) begin
                burstActive <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array, one flop memory per lane
    logic [LANES*sbsp_pkg::LANE_BITS-1:0] readData;
    logic [LANES-1:0]                     readParity;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_mem
            logic [sbsp_pkg::LANE_WORD-1:0] laneMem [DEPTH];

            // byte and parity written on the edge of the write access
            always_ff @(posedge clk) begin
                if (doAccess && accWrite && laneMask[g]) begin
                    laneMem[accAddr] <= {parityLaneIn[g],
                        dataLaneIn[g*sbsp_pkg::LANE_BITS +: sbsp_pkg::LANE_BITS]};
                end
            end

            assign readData[g*sbsp_pkg::LANE_BITS +: sbsp_pkg::LANE_BITS] =
                laneMem[accAddr][sbsp_pkg::LANE_BITS-1:0];
            assign readParity[g] = laneMem[accAddr][sbsp_pkg::PARITY_POS];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // output data and drive
    logic next_readCycle;
    logic next_dataOe_n;

    assign next_readCycle = doAccess ? !accWrite : (doDeselect || !awake) ? 1'b0 : readCycle;
    // drive only on a read while awake with output enable low
    assign next_dataOe_n  = !(next_readCycle && !oeSync && awake && !sleepSync);

    // read data is latched on the edge of the read access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataLaneOut   <= '0;
            parityLaneOut <= '0;
        end else if (doAccess && !accWrite) begin
            dataLaneOut   <= readData;
            parityLaneOut <= readParity;
        end
    end

    // read-cycle flag and output enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readCycle <= 1'b0;
            dataOe_n  <= 1'b1;
        end else begin
            readCycle <= next_readCycle;
            dataOe_n  <= next_dataOe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SYNC_TWO_STAGE: assert property (@(posedge clk) disable iff (!rst_n)
        ##2 (sleepSync == $past(sleepRequest, 2)))
        else $error("sleep request not seen two flops later");

    AST_SLEEP_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
        (sleepState != sbsp_pkg::SLP_AWAKE) |=> dataOe_n && $stable(baseHigh))
        else $error("pins driven or state lost while asleep");

    AST_WAKE_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        (sleepState == sbsp_pkg::SLP_ASLEEP && !sleepSync) ##1 (!sleepSync)[*2]
        |-> !awake ##1 awake)
        else $error("wake-up not two cycles");

    AST_READ_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
        (globalWrite_n && (byteWriteEn_n || &laneWrite_n)) |-> !writeReq)
        else $error("read inputs decoded as write");

    AST_GLOBAL_ALL: assert property (@(posedge clk) disable iff (!rst_n)
        !globalWrite_n |-> &laneMask && writeReq)
        else $error("global write missed a lane");

    AST_PROC_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && !procAddrStrobe_n && allSelected)
        |=> burstActive && readCycle && beat == sbsp_pkg::BEAT_FIRST && startBits == $past(extAddr[1:0]))
        else $error("processor strobe did not begin a read burst");

    AST_DESELECT: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && !procTaken && !ctrlAddrStrobe_n && !allSelected) |=> !burstActive && dataOe_n)
        else $error("deselect did not end the burst");

    AST_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && burstActive && procAddrStrobe_n && ctrlAddrStrobe_n && !burstStep_n)
        |=> beat == 2'($past(beat) + sbsp_pkg::BEAT_STEP))
        else $error("advance did not step the counter");

    AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && procAddrStrobe_n && ctrlAddrStrobe_n && burstStep_n) |=> $stable(beat))
        else $error("wait state moved the counter");

    AST_OE_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
        (oeSync || (doAccess && accWrite)) |=> dataOe_n)
        else $error("pins driven with output enable high or on a write");

    AST_LANE_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
        (globalWrite_n && !byteWriteEn_n) |-> laneMask == ~laneWrite_n)
        else $error("lane write reached a lane other than its own");

    AST_PRIMARY_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && chipSelPrimary_n && ctrlAddrStrobe_n) |-> !doLoad && !doDeselect)
        else $error("processor strobe acted while primary select high");

    AST_CTRL_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && procAddrStrobe_n && !ctrlAddrStrobe_n && allSelected) |-> doLoad && accWrite == writeReq)
        else $error("controller strobe load took the wrong direction");

    AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        (doAdvance && &beat) |-> accAddr[1:0] == startBits)
        else $error("burst counter did not wrap to its start");

    AST_LINEAR_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (doAdvance && beat == sbsp_pkg::BEAT_FIRST && orderSync == sbsp_pkg::ORDER_LINEAR)
        |-> accAddr[1:0] == 2'(startBits + sbsp_pkg::BEAT_STEP))
        else $error("linear burst did not step by one");

    AST_INTERLEAVE_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (doAdvance && beat == sbsp_pkg::BEAT_FIRST && orderSync != sbsp_pkg::ORDER_LINEAR)
        |-> accAddr[1:0] == (startBits ^ sbsp_pkg::BEAT_STEP))
        else $error("interleaved burst did not flip the low bit");

    AST_IDLE_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
        (doDeselect || !awake) |=> dataOe_n)
        else $error("pins driven while deselected or asleep");

    COV_PROC_READ: cover property (@(posedge clk) disable iff (!rst_n)
        procTaken && allSelected ##1 !dataOe_n);
    COV_CTRL_WRITE_BURST: cover property (@(posedge clk) disable iff (!rst_n)
        doLoad && accWrite ##1 doAdvance && accWrite ##1 doAdvance);
    COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n)
        sleepState == sbsp_pkg::SLP_WAKING ##1 awake);
    COV_INTERLEAVED_STEP: cover property (@(posedge clk) disable iff (!rst_n)
        doAdvance && orderSync != sbsp_pkg::ORDER_LINEAR);
endmodule

//--- testbench/sbsp_bus_master.sv
// bus master model: drives address, strobes, selects, write controls and write data
`timescale 1ns/10ps
module sbsp_bus_master (
    input  wire logic        clk,
    output logic [5:0]       extAddr,
    output logic             procAddrStrobe_n,
    output logic             ctrlAddrStrobe_n,
    output logic             burstStep_n,
    output logic             globalWrite_n,
    output logic             byteWriteEn_n,
    output logic [3:0]       laneWrite_n,
    output logic             chipSelPrimary_n,
    output logic             chipSelSecondary,
    output logic             chipSelSecondary_n,
    output logic [31:0]      dataLaneIn,
    output logic [3:0]       parityLaneIn
);
    // idle levels at time zero: strobes high, device deselected
    initial begin
        {procAddrStrobe_n, ctrlAddrStrobe_n, burstStep_n, globalWrite_n, byteWriteEn_n} = 5'h1f;
        {chipSelPrimary_n, chipSelSecondary, chipSelSecondary_n} = 3'h0;
        laneWrite_n = 4'hf;
        extAddr = 6'h00;
        {parityLaneIn, dataLaneIn} = 36'h0_0000_0000;
    end

    // one request per edge, held until the following edge samples it
    task automatic drive(input logic [4:0] ctl, input logic [3:0] we, input logic [5:0] a,
                         input logic [35:0] d, input logic [2:0] sel);
        @(posedge clk);
        {procAddrStrobe_n, ctrlAddrStrobe_n, burstStep_n, globalWrite_n, byteWriteEn_n} <= ctl;
        laneWrite_n <= we;
        extAddr <= a;
        {chipSelPrimary_n, chipSelSecondary, chipSelSecondary_n} <= sel;
        // data only on write cycles; otherwise lines toggle like a released bus
        if (!ctl[1] || (!ctl[0] && !(&we))) begin
            {parityLaneIn, dataLaneIn} <= d;
        end else begin
            {parityLaneIn, dataLaneIn} <= ~{parityLaneIn, dataLaneIn};
        end
    endtask
endmodule

//--- testbench/sbsp_sync_burst_sram_port_tb.sv
// self-checking bench for the synchronous burst sram port
`timescale 1ns/10ps
module sbsp_sync_burst_sram_port_tb;
    typedef struct packed {logic gw; logic bw; logic [3:0] we; logic [3:0] mask;} sbsp_row_t;
    localparam logic [4:0] CW = 5'h15, PR = 5'h0f, PRS = 5'h0b, PW = 5'h0d, SW = 5'h19, NP = 5'h1f, ID = 5'h17;
    localparam logic [2:0] SEL = 3'h2, DS = 3'h0, PH = 3'h6, SN = 3'h3;
    logic        clk = 1'b0, rst_n = 1'b0, outputEnable_n = 1'b0, burstOrderSelect = 1'b0, sleepRequest = 1'b0;
    logic [5:0]  extAddr;
    logic        procAddrStrobe_n, ctrlAddrStrobe_n, burstStep_n, globalWrite_n, byteWriteEn_n;
    logic        chipSelPrimary_n, chipSelSecondary, chipSelSecondary_n, dataOe_n;
    logic [3:0]  laneWrite_n, parityLaneIn, parityLaneOut;
    logic [31:0] dataLaneIn, dataLaneOut;
    logic [35:0] ex [64];
    int          fail_count = 0, num_checks = 0;
    sbsp_row_t   rows [8] = '{'{1'b1, 1'b1, 4'h0, 4'h0}, '{1'b1, 1'b0, 4'hf, 4'h0}, '{1'b1, 1'b0, 4'he, 4'h1},
                              '{1'b1, 1'b0, 4'hd, 4'h2}, '{1'b1, 1'b0, 4'h3, 4'hc}, '{1'b1, 1'b0, 4'h0, 4'hf},
                              '{1'b0, 1'b1, 4'hf, 4'hf}, '{1'b0, 1'b0, 4'h5, 4'hf}};

    always #4 clk = ~clk;

    sbsp_sync_burst_sram_port #(.LANES(4), .ADDR_W(6)) dut (.clk, .rst_n, .extAddr, .procAddrStrobe_n,
        .ctrlAddrStrobe_n, .burstStep_n, .globalWrite_n, .byteWriteEn_n, .laneWrite_n, .chipSelPrimary_n,
        .chipSelSecondary, .chipSelSecondary_n, .outputEnable_n, .burstOrderSelect, .sleepRequest,
        .dataLaneIn, .parityLaneIn, .dataLaneOut, .parityLaneOut, .dataOe_n);
    sbsp_bus_master m (.clk, .extAddr, .procAddrStrobe_n, .ctrlAddrStrobe_n, .burstStep_n, .globalWrite_n,
        .byteWriteEn_n, .laneWrite_n, .chipSelPrimary_n, .chipSelSecondary, .chipSelSecondary_n,
        .dataLaneIn, .parityLaneIn);

    ////////////////////////////////////////////////////////////////////////////////
    // compare, model and closing helpers
    task automatic chk(input logic [36:0] g, input logic [36:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [36:0] got();
        return {dataOe_n, parityLaneOut, dataLaneOut};
    endfunction
    // update the expected array for the lanes in mask
    task automatic put(input logic [5:0] a, input logic [3:0] msk, input logic [35:0] d);
        for (int l = 0; l < 4; l++) begin
            if (msk[l]) begin
                ex[a][8*l +: 8] = d[8*l +: 8];
                ex[a][32+l] = d[32+l];
            end
        end
    endtask
    task automatic idle();
        m.drive(ID, 4'hf, 6'h00, 36'h0_0000_0000, DS);
    endtask
    task automatic nop();
        m.drive(NP, 4'hf, 6'h00, 36'h0_0000_0000, SEL);
    endtask
    // single read, then a deselect edge, then compare data and drive enable
    task automatic rd(input logic [5:0] a);
        m.drive(PR, 4'hf, a, 36'h0_0000_0000, SEL);
        idle();
        #1 chk(got(), {1'b0, ex[a]});
    endtask
    function automatic logic [35:0] pat(input int b);
        return {4'h5 ^ 4'(b), 32'h1234_5600 + 32'(b)};
    endfunction
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [1:0] bt;
        logic [4:0] sn;
        logic [2:0] dsel [6];
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(got(), {1'b1, 36'h0_0000_0000});
        $display("test reset done");
        // table rows: fill with ones, apply the row's write controls with zero data, read back
        for (int i = 0; i < 8; i++) begin
            m.drive(CW, 4'hf, 6'(16 + i), 36'hf_ffff_ffff, SEL);
            put(6'(16 + i), 4'hf, 36'hf_ffff_ffff);
            idle();
            m.drive({3'h5, rows[i].gw, rows[i].bw}, rows[i].we, 6'(16 + i), 36'h0_0000_0000, SEL);
            put(6'(16 + i), rows[i].mask, 36'h0_0000_0000);
            idle();
            rd(6'(16 + i));
        end
        $display("test write table done");
        // burst write from low bits 01, stepping each edge
        @(posedge clk) outputEnable_n <= 1'b1;
        repeat (3) idle();
        m.drive(CW, 4'hf, 6'h21, pat(0), SEL);
        put(6'h21, 4'hf, pat(0));
        for (int b = 1; b < 4; b++) begin
            m.drive(SW, 4'hf, 6'h00, pat(b), SEL);
            put({4'h8, 2'(1 + b)}, 4'hf, pat(b));
            #1 chk({36'h0_0000_0000, dataOe_n}, 37'h1);
        end
        idle();
        $display("test burst write done");
        // burst reads in both orders: step held low at load, one wait state, wrap after four
        sn = 5'h02;
        outputEnable_n <= 1'b0;
        for (int ord = 0; ord < 2; ord++) begin
            @(posedge clk) burstOrderSelect <= ord[0];
            repeat (4) idle();
            bt = 2'h0;
            m.drive(PRS, 4'hf, 6'h21, 36'h0_0000_0000, SEL);
            for (int k = 0; k < 5; k++) begin
                m.drive({2'h3, sn[k], 2'h3}, 4'hf, 6'h00, 36'h0_0000_0000, SEL);
                #1 chk(got(), {1'b0, ex[{4'h8, ord ? 2'h1 ^ bt : 2'h1 + bt}]});
                if (!sn[k]) bt++;
            end
            idle();
            #1 chk(got(), {1'b0, ex[{4'h8, ord ? 2'h1 ^ bt : 2'h1 + bt}]});
        end
        $display("test burst read done");
        // deselect cases: none may write or drive; proc strobe with primary high is ignored
        m.drive(CW, 4'hf, 6'h28, 36'hf_ffff_ffff, SEL);
        put(6'h28, 4'hf, 36'hf_ffff_ffff);
        dsel = '{PH, DS, SN, DS, SN, PH};
        for (int k = 0; k < 6; k++) begin
            m.drive(k < 3 ? CW : PW, 4'hf, 6'h28, 36'h0_0000_0000, dsel[k]);
            nop();
            #1 chk({36'h0_0000_0000, dataOe_n}, 37'h1);
        end
        m.drive(PW, 4'hf, 6'h28, 36'h0_0000_0000, SEL);
        m.drive(PR, 4'hf, 6'h00, 36'h0_0000_0000, PH);
        #1 chk(got(), {1'b0, ex[6'h28]});
        nop();
        #1 chk(got(), {1'b0, ex[6'h28]});
        idle();
        rd(6'h28);
        $display("test deselect done");
        // sleep during wait-state reads, then wake and read back
        m.drive(PR, 4'hf, 6'h21, 36'h0_0000_0000, SEL);
        nop();
        #1 chk(got(), {1'b0, ex[6'h21]});
        @(posedge clk) sleepRequest <= 1'b1;
        repeat (6) nop();
        #1 chk({36'h0_0000_0000, dataOe_n}, 37'h1);
        @(posedge clk) sleepRequest <= 1'b0;
        repeat (8) nop();
        rd(6'h21);
        $display("test sleep done");
        // output enable high keeps the pins released on a read
        @(posedge clk) outputEnable_n <= 1'b1;
        repeat (4) idle();
        m.drive(PR, 4'hf, 6'h21, 36'h0_0000_0000, SEL);
        idle();
        #1 chk({36'h0_0000_0000, dataOe_n}, 37'h1);
        $display("test output enable done");
        close_out();
    end
endmodule
